// ### verilog/bcwc_exec.sv
// Contract
// - a bit clear forces the selected bit of the addressed byte to 0, keeps the rest, touches no flag.
// - the plain watchdog clear restarts the watchdog and zeroes whichever of the time-out and power-down flags has no set request in the same cycle.
// - the first pre-clear acts on watchdog and both flags when it is the first pre-clear since reset or alternates with the second.
// - a repeated first pre-clear with no second in between only raises the done pulse.
// - the second pre-clear acts when it is the first pre-clear since reset or alternates with the first; repeating it only raises the done pulse.
`timescale 1ns/1ps

module bcwc_exec
(
  // clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  rst_in,
  // instruction from the decoder
  input  wire logic                  instr_valid_in,
  input  bcwc_pkg::bcwc_op_e         instr_op_in,
  input  wire bcwc_pkg::bcwc_addr_t  instr_addr_in,
  input  wire bcwc_pkg::bcwc_bitsel_t instr_bitsel_in,
  // data memory read port, same cycle as the instruction
  input  wire bcwc_pkg::bcwc_data_t  mem_rdata_in,
  // flag set requests from watchdog and sleep logic
  input  wire logic                  timeout_set_in,
  input  wire logic                  powerdown_set_in,
  // data memory write port
  output logic                       mem_wr_out,
  output bcwc_pkg::bcwc_addr_t       mem_waddr_out,
  output bcwc_pkg::bcwc_data_t       mem_wdata_out,
  // watchdog and status
  output logic                       watchdog_counter_clr_out,
  output logic                       timeout_flag_out,
  output logic                       powerdown_flag_out,
  output bcwc_pkg::bcwc_pre_e        preclear_last_out,
  output logic                       instr_done_out
);

  import bcwc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // one-hot mask of the selected bit
  function automatic bcwc_data_t bit_mask(input bcwc_bitsel_t sel);
    bcwc_data_t m;
    m = '0;
    m[sel] = 1'b1;
    return m;
  endfunction

  // true when a valid instruction carries the given operation
  function automatic logic is_op(input logic vld, input bcwc_op_e op, input bcwc_op_e want);
    return vld && (op == want);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic       bit_clear_instr;
  logic       watchdog_clear_instr;
  logic       preclear_first_instr;
  logic       preclear_second_instr;
  logic       pre_fire;
  logic       flag_clear;
  bcwc_pre_e  pre_last;
  bcwc_data_t cleared_byte;

  assign bit_clear_instr       = is_op(instr_valid_in, instr_op_in, BCWC_OP_BITCLR);
  assign watchdog_clear_instr  = is_op(instr_valid_in, instr_op_in, BCWC_OP_WDTCLR);
  assign preclear_first_instr  = is_op(instr_valid_in, instr_op_in, BCWC_OP_PRE1);
  assign preclear_second_instr = is_op(instr_valid_in, instr_op_in, BCWC_OP_PRE2);

  ////////////////////////////////////////////////////////////////////////////
  // pre-clear alternation

  bcwc_preclear_track i_bcwc_preclear_track
  (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .pre1_go_in (preclear_first_instr),
    .pre2_go_in (preclear_second_instr),
    .fire_out   (pre_fire),
    .last_out   (pre_last)
  );

  // plain clear acts at once, pre-clears on alternation or as the first pre-clear since reset
  assign flag_clear = watchdog_clear_instr
                    | pre_fire;

  ////////////////////////////////////////////////////////////////////////////
  // bit clear datapath
  // read-modify-write in one cycle; the write lands one edge later, so a
  // read of the same byte in the very next cycle must be forwarded upstream

  always_comb
  begin
    cleared_byte = mem_rdata_in;
    cleared_byte[instr_bitsel_in] = `BCWC_CLEARED_BIT;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      mem_wr_out <= `BCWC_RST_PULSE;
    else
      mem_wr_out <= bit_clear_instr;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mem_waddr_out <= `BCWC_RST_ADDR;
      mem_wdata_out <= `BCWC_RST_DATA;
    end
    else if (bit_clear_instr)
    begin
      mem_waddr_out <= instr_addr_in;
      // other bits keep the value read
      mem_wdata_out <= cleared_byte & ~bit_mask(instr_bitsel_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog restart pulse

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      watchdog_counter_clr_out <= `BCWC_RST_PULSE;
    else
      watchdog_counter_clr_out <= flag_clear;
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags
  // a set from the watchdog or sleep logic beats a clear in the same cycle,
  // so a time-out is never lost to a racing clear instruction.
  // bit clear never reaches these flops

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      timeout_flag_out <= `BCWC_RST_TIMEOUT;
    else if (timeout_set_in)
      timeout_flag_out <= 1'b1;
    else if (flag_clear)
      timeout_flag_out <= 1'b0;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      powerdown_flag_out <= `BCWC_RST_POWERDOWN;
    else if (powerdown_set_in)
      powerdown_flag_out <= 1'b1;
    else if (flag_clear)
      powerdown_flag_out <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // visibility of the alternation record and completion

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      preclear_last_out <= BCWC_PRE_NONE;
    else
      preclear_last_out <= pre_last;
  end

  // ignored pre-clears still complete; only their effect is dropped
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      instr_done_out <= `BCWC_RST_PULSE;
    else
      instr_done_out <= bit_clear_instr | watchdog_clear_instr
                      | preclear_first_instr | preclear_second_instr;
  end

endmodule // bcwc_exec

// ### shared/bcwc_consts.svh
`ifndef BCWC_CONSTS_SVH
`define BCWC_CONSTS_SVH

// data memory geometry
`define BCWC_DATA_W        8
`define BCWC_ADDR_W        8
`define BCWC_BITSEL_W      3

// reset values of the status flags and pulses
`define BCWC_RST_TIMEOUT   1'b0
`define BCWC_RST_POWERDOWN 1'b0
`define BCWC_RST_PULSE     1'b0
`define BCWC_RST_ADDR      8'h00
`define BCWC_RST_DATA      8'h00

// value a cleared bit takes
`define BCWC_CLEARED_BIT   1'b0

`endif

// ### shared/bcwc_pkg.sv
`include "bcwc_consts.svh"

package bcwc_pkg;

  typedef logic [`BCWC_DATA_W-1:0]   bcwc_data_t;
  typedef logic [`BCWC_ADDR_W-1:0]   bcwc_addr_t;
  typedef logic [`BCWC_BITSEL_W-1:0] bcwc_bitsel_t;

  // operation handed over by the instruction decoder
  typedef enum logic [2:0]
  {
    BCWC_OP_OTHER   = 3'h0,
    BCWC_OP_BITCLR  = 3'h1,
    BCWC_OP_WDTCLR  = 3'h2,
    BCWC_OP_PRE1    = 3'h3,
    BCWC_OP_PRE2    = 3'h4
  } bcwc_op_e;

  // which pre-clear instruction ran last, gray coded along none->first->second
  typedef enum logic [1:0]
  {
    BCWC_PRE_NONE   = 2'h0,
    BCWC_PRE_FIRST  = 2'h1,
    BCWC_PRE_SECOND = 2'h3
  } bcwc_pre_e;

endpackage

// ### verilog/bcwc_preclear_track.sv
`timescale 1ns/1ps

module bcwc_preclear_track
(
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  // executed pre-clear instructions
  input  wire logic              pre1_go_in,
  input  wire logic              pre2_go_in,
  // result
  output logic                   fire_out,
  output bcwc_pkg::bcwc_pre_e    last_out
);

  import bcwc_pkg::*;

  bcwc_pre_e last_r;
  bcwc_pre_e last_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // alternation check: a pre-clear only counts when it differs from the last
  always_comb
  begin
    fire_out = 1'b0;
    last_nxt = last_r;
    case (last_r)
      BCWC_PRE_NONE:
      begin
        // after reset either half may come first
        if (pre1_go_in)
        begin
          fire_out = 1'b1;
          last_nxt = BCWC_PRE_FIRST;
        end
        else if (pre2_go_in)
        begin
          fire_out = 1'b1;
          last_nxt = BCWC_PRE_SECOND;
        end
      end
      BCWC_PRE_FIRST:
      begin
        // repeated first half is ignored
        if (pre2_go_in)
        begin
          fire_out = 1'b1;
          last_nxt = BCWC_PRE_SECOND;
        end
      end
      BCWC_PRE_SECOND:
      begin
        // repeated second half is ignored
        if (pre1_go_in)
        begin
          fire_out = 1'b1;
          last_nxt = BCWC_PRE_FIRST;
        end
      end
      default:
      begin
        fire_out = 1'b0;
        last_nxt = BCWC_PRE_NONE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // record of the last pre-clear half
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      last_r <= BCWC_PRE_NONE;
    else
      last_r <= last_nxt;
  end

  assign last_out = last_r;

endmodule // bcwc_preclear_track

// ### test/bcwc_exec_monitor.sv
`timescale 1ns/1ps

module bcwc_exec_chk
(
  // clock and reset
  input wire logic                   clock_in,
  input wire logic                   rst_in,
  // instruction side
  input wire logic                   instr_valid_in,
  input bcwc_pkg::bcwc_op_e          instr_op_in,
  input wire bcwc_pkg::bcwc_bitsel_t instr_bitsel_in,
  input wire bcwc_pkg::bcwc_data_t   mem_rdata_in,
  input wire logic                   timeout_set_in,
  input wire logic                   powerdown_set_in,
  // results
  input wire logic                   mem_wr_out,
  input wire bcwc_pkg::bcwc_data_t   mem_wdata_out,
  input wire logic                   watchdog_counter_clr_out,
  input wire logic                   timeout_flag_out,
  input wire logic                   powerdown_flag_out,
  input bcwc_pkg::bcwc_pre_e         preclear_last_out,
  input wire logic                   instr_done_out
);
  import bcwc_pkg::*;
  wire logic bc = instr_valid_in && instr_op_in == BCWC_OP_BITCLR;
  wire logic wc = instr_valid_in && instr_op_in == BCWC_OP_WDTCLR;
  wire logic p1 = instr_valid_in && instr_op_in == BCWC_OP_PRE1;
  wire logic p2 = instr_valid_in && instr_op_in == BCWC_OP_PRE2;
  wire logic ns = !timeout_set_in && !powerdown_set_in;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // a repeat is judged by the second half only, whatever the first did
  sequence s_rep1; p1 ##1 p1; endsequence
  sequence s_rep2; p2 ##1 p2; endsequence
  sequence s_alt; p1 ##1 (p2 && ns); endsequence

  a_bit_write: assert property (bc |=> mem_wr_out && mem_wdata_out ==
    ($past(mem_rdata_in) & ~(8'h01 << $past(instr_bitsel_in))))
    else $error("bit clear wrote a wrong byte");
  a_bit_noflag: assert property (bc && ns |=>
    $stable({timeout_flag_out, powerdown_flag_out})) else $error("bit clear moved a flag");
  a_watchdog_clear: assert property (wc && ns |=> watchdog_counter_clr_out &&
    !timeout_flag_out && !powerdown_flag_out) else $error("watchdog clear incomplete");
  a_alt_clear: assert property (s_alt |=> watchdog_counter_clr_out &&
    !timeout_flag_out && !powerdown_flag_out) else $error("alternating pre-clear lost");
  a_rep1_none: assert property (s_rep1 |=> !watchdog_counter_clr_out &&
    !$fell(timeout_flag_out)) else $error("repeated first pre-clear acted");
  a_rep2_none: assert property (s_rep2 |=> !watchdog_counter_clr_out &&
    !$fell(powerdown_flag_out)) else $error("repeated second pre-clear acted");
  a_rec_track: assert property (s_alt |-> ##2 preclear_last_out == BCWC_PRE_SECOND)
    else $error("pre-clear record not second");
  a_done_pulse: assert property (bc || wc || p1 || p2 |=> instr_done_out)
    else $error("done pulse missing");
endmodule // bcwc_exec_chk

bind bcwc_exec bcwc_exec_chk i_bcwc_exec_chk
(
  .clock_in(clock_in), .rst_in(rst_in), .instr_valid_in(instr_valid_in),
  .instr_op_in(instr_op_in), .instr_bitsel_in(instr_bitsel_in),
  .mem_rdata_in(mem_rdata_in), .timeout_set_in(timeout_set_in),
  .powerdown_set_in(powerdown_set_in), .mem_wr_out(mem_wr_out),
  .mem_wdata_out(mem_wdata_out), .watchdog_counter_clr_out(watchdog_counter_clr_out),
  .timeout_flag_out(timeout_flag_out), .powerdown_flag_out(powerdown_flag_out),
  .preclear_last_out(preclear_last_out), .instr_done_out(instr_done_out)
);

// ### test/tb_bcwc_exec.sv
`timescale 1ns/1ps

module tb_bcwc_exec;
  import bcwc_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic vld = 1'b0;
  bcwc_op_e op = BCWC_OP_OTHER;
  bcwc_addr_t adr = 8'h00;
  bcwc_bitsel_t sel = 3'h0;
  bcwc_data_t rd = 8'h00;
  logic tset = 1'b0;
  logic pset = 1'b0;
  logic wr, clr, tof, pdn, done;
  bcwc_addr_t wa;
  bcwc_data_t wd;
  bcwc_pre_e last;
  int n_fail = 0;
  int total_checks = 0;

  always #2.5 clock_in = ~clock_in;

  bcwc_exec i_bcwc_exec
  (
    .clock_in(clock_in), .rst_in(rst_in), .instr_valid_in(vld), .instr_op_in(op),
    .instr_addr_in(adr), .instr_bitsel_in(sel), .mem_rdata_in(rd),
    .timeout_set_in(tset), .powerdown_set_in(pset), .mem_wr_out(wr),
    .mem_waddr_out(wa), .mem_wdata_out(wd), .watchdog_counter_clr_out(clr),
    .timeout_flag_out(tof), .powerdown_flag_out(pdn), .preclear_last_out(last),
    .instr_done_out(done)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // valid stays up after go so back-to-back issues are possible
  task automatic go(input bcwc_op_e o, input logic [7:0] d = 8'h00, input logic [2:0] s = 3'h0);
    vld = 1'b1;
    op = o;
    rd = d;
    sel = s;
    adr = ~d;
    @(negedge clock_in);
  endtask

  task automatic setf();
    vld = 1'b0;
    tset = 1'b1;
    pset = 1'b1;
    @(negedge clock_in);
    tset = 1'b0;
    pset = 1'b0;
  endtask

  task automatic do_reset();
    vld = 1'b0;
    rst_in = 1'b1;
    repeat (6) @(negedge clock_in);
    rst_in = 1'b0;
  endtask

  task automatic cwd(input logic c, input logic f);
    chk("clr", clr, c);
    chk("timeout", tof, f);
    chk("powerdown", pdn, f);
    chk("done", done, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_pre();
    do_reset();
    go(BCWC_OP_PRE2);
    cwd(1'b1, 1'b0);
    go(BCWC_OP_PRE2);
    cwd(1'b0, 1'b0);
    setf();
    go(BCWC_OP_PRE2);
    cwd(1'b0, 1'b1);
    go(BCWC_OP_PRE1);
    cwd(1'b1, 1'b0);
    go(BCWC_OP_PRE1);
    cwd(1'b0, 1'b0);
    setf();
    go(BCWC_OP_PRE1);
    cwd(1'b0, 1'b1);
    go(BCWC_OP_PRE2);
    cwd(1'b1, 1'b0);
    vld = 1'b0;
    repeat (2) @(negedge clock_in);
    chk("record", last, BCWC_PRE_SECOND);
    // flags raised and record at second, so only a real reset passes below
    setf();
    do_reset();
    chk("reset state", {tof, pdn, last}, 8'h00);
    go(BCWC_OP_PRE2);
    cwd(1'b1, 1'b0);
    go(BCWC_OP_PRE1);
    cwd(1'b1, 1'b0);
    do_reset();
    go(BCWC_OP_PRE1);
    cwd(1'b1, 1'b0);
    $display("t_pre done");
  endtask

  task automatic t_wdt();
    setf();
    go(BCWC_OP_WDTCLR);
    cwd(1'b1, 1'b0);
    go(BCWC_OP_WDTCLR);
    cwd(1'b1, 1'b0);
    // a set racing the clear wins, the restart pulse still goes out
    tset = 1'b1;
    pset = 1'b1;
    go(BCWC_OP_WDTCLR);
    tset = 1'b0;
    pset = 1'b0;
    cwd(1'b1, 1'b1);
    go(BCWC_OP_OTHER);
    chk("clr other", clr, 1'b0);
    chk("done other", done, 1'b0);
    chk("wr other", wr, 1'b0);
    chk("flags other", {tof, pdn}, 2'h3);
    $display("t_wdt done");
  endtask

  // flags held high to show a bit clear leaves them alone
  task automatic t_bit();
    logic [7:0] d;
    setf();
    for (int k = 0; k < 8; k++)
    begin
      d = 8'hff - 8'(k * 17);
      go(BCWC_OP_BITCLR, d, 3'(k));
      chk("wr", wr, 1'b1);
      chk("waddr", wa, ~d);
      chk("wdata", wd, d & ~(8'h01 << k));
      chk("flags", {tof, pdn}, 2'h3);
    end
    vld = 1'b0;
    @(negedge clock_in);
    chk("wr idle", wr, 1'b0);
    $display("t_bit done");
  endtask

  task automatic complete_run();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    t_pre();
    t_wdt();
    t_bit();
    complete_run();
  end
endmodule // tb_bcwc_exec
